// file: rtl/mcis_pkg.sv
// package: constants, opcode classes and states of the instruction execution core
package mcis_pkg;

   //==========================================================
   // widths
   localparam int unsigned INSTR_W  = 14;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned PC_W     = 13;
   localparam int unsigned FADDR_W  = 7;
   localparam int unsigned JUMP_W   = 11;

   //==========================================================
   // instruction and page latch field positions
   localparam int unsigned FADDR_LSB = 0;
   localparam int unsigned DEST_BIT  = 7;
   localparam int unsigned LIT_LSB   = 0;
   localparam int unsigned JUMP_LSB  = 0;
   localparam int unsigned PAGE_HI   = 4;
   localparam int unsigned PAGE_LO   = 3;

   //==========================================================
   // reset values and step constants
   localparam logic [PC_W-1:0]    PC_RST    = 13'h0000;
   localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
   localparam logic [INSTR_W-1:0] IR_RST    = 14'h0000;
   localparam logic [DATA_W-1:0]  ONE       = 8'h01;
   localparam logic [PC_W-1:0]    PC_STEP   = 13'h0001;

   //==========================================================
   // operation classes
   typedef enum logic [3:0] {
      op_no_operation,
      op_complement_reg,
      op_decrement_skip_zero,
      op_increment_skip_zero,
      op_jump_absolute,
      op_or_literal,
      op_move_reg,
      op_load_literal,
      op_store_accumulator,
      op_return_from_irq,
      op_return_with_literal,
      op_return_sub,
      op_load_timer_cfg,
      op_rotate_right_carry,
      op_unsupported
   } mcis_op_t;

   //==========================================================
   // execute states
   typedef enum logic {
      st_exec,
      st_flush
   } mcis_state_t;

endpackage

// file: rtl/mcis_exec_if.sv
// interface: decoded operation and datapath results between core modules
`timescale 1ns/100ps
interface mcis_exec_if;
   import mcis_pkg::*;

   logic [INSTR_W-1:0] instr;
   mcis_op_t           op;
   logic [DATA_W-1:0]  operand;
   logic [DATA_W-1:0]  acc;
   logic               carry_in;
   logic [DATA_W-1:0]  result;
   logic               zero;
   logic               carry_out;

   modport dec  (input instr, output op);
   modport alu  (input op, input instr, input operand, input acc, input carry_in,
                 output result, output zero, output carry_out);
   modport core (output instr, output operand, output acc, output carry_in,
                 input op, input result, input zero, input carry_out);
endinterface // mcis_exec_if

// file: rtl/mcis_decode.sv
// module: instruction word classifier
`timescale 1ns/100ps
module mcis_decode
   import mcis_pkg::*;
(
   mcis_exec_if.dec ex
);

   //==========================================================
   // classification
   // wildcard positions are never compared, so any filler is accepted
   always_comb begin
      casez (ex.instr) // RULE10
         14'b00_0000_1???_????: ex.op = op_store_accumulator; // RULE11
         14'b00_0000_0??0_0000: ex.op = op_no_operation; // RULE19
         14'b00_0000_0000_1001: ex.op = op_return_from_irq;
         14'b00_0000_0000_1000: ex.op = op_return_sub;
         14'b00_0000_0110_0010: ex.op = op_load_timer_cfg;
         14'b00_1001_????_????: ex.op = op_complement_reg;
         14'b00_1011_????_????: ex.op = op_decrement_skip_zero;
         14'b00_1111_????_????: ex.op = op_increment_skip_zero;
         14'b00_1000_????_????: ex.op = op_move_reg;
         14'b00_1100_????_????: ex.op = op_rotate_right_carry;
         14'b10_1???_????_????: ex.op = op_jump_absolute;
         14'b11_1000_????_????: ex.op = op_or_literal;
         14'b11_00??_????_????: ex.op = op_load_literal; // RULE10
         14'b11_01??_????_????: ex.op = op_return_with_literal;
         default:               ex.op = op_unsupported;
      endcase
   end

endmodule // mcis_decode

// file: rtl/mcis_alu.sv
// module: datapath results and flags for one decoded operation
`timescale 1ns/100ps
module mcis_alu
   import mcis_pkg::*;
(
   mcis_exec_if.alu ex
);

   logic [DATA_W-1:0] literal;

   assign literal = ex.instr[LIT_LSB +: DATA_W];

   //==========================================================
   // result
   always_comb begin
      ex.carry_out = ex.carry_in;
      case (ex.op)
         op_complement_reg:      ex.result = ~ex.operand; // RULE18
         op_decrement_skip_zero: ex.result = ex.operand - ONE; // RULE2
         op_increment_skip_zero: ex.result = ex.operand + ONE; // RULE3
         op_move_reg:            ex.result = ex.operand; // RULE20
         op_rotate_right_carry: begin
            ex.result    = {ex.carry_in, ex.operand[DATA_W-1:1]}; // RULE17
            ex.carry_out = ex.operand[0]; // RULE17
         end
         op_or_literal:          ex.result = ex.acc | literal; // RULE8
         op_load_literal:        ex.result = literal; // RULE9
         op_return_with_literal: ex.result = literal; // RULE14
         op_store_accumulator:   ex.result = ex.acc;
         op_load_timer_cfg:      ex.result = ex.acc;
         default:                ex.result = ex.acc;
      endcase
   end

   assign ex.zero = (ex.result == '0);

endmodule // mcis_alu

// file: rtl/mcis_core.sv
// module: execution core for a subset of a 14-bit instruction set
// Overview of operation
// [RULE1] 7-bit register address; destination bit picks target
// [RULE2] decrement-skip: minus one, no flags, skip zero
// [RULE3] increment-skip: plus one, no flags, skip zero
// [RULE4] met skip drops prefetch, runs empty cycle
// [RULE5] jump loads 11-bit immediate into low counter
// [RULE6] jump upper counter bits from page latch
// [RULE7] jump takes two cycles, prefetch flushed
// [RULE8] or-literal into accumulator, zero flag only
// [RULE9] load-literal into accumulator, no flags, one cycle
// [RULE10] wildcard opcode bits ignored, written as zeros
// [RULE11] store accumulator to register, no flags
// [RULE12] irq return pops stack, sets enable, two cycles
// [RULE13] timer config load from accumulator, no flags
// [RULE14] return-literal loads accumulator, no flags
// [RULE15] return-literal pops counter, two cycles total
// [RULE16] subroutine return pops counter, two cycles
// [RULE17] rotate right through carry, carry flag only
// [RULE18] complement register, zero flag on zero result
// [RULE19] no-operation only advances counter, one cycle
// [RULE20] move register to destination, sets zero flag
`timescale 1ns/100ps
module mcis_core
   import mcis_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   // program memory
   output      logic [PC_W-1:0]    prog_addr,
   input  wire logic [INSTR_W-1:0] prog_data,
   // register file
   output      logic [FADDR_W-1:0] file_raddr,
   input  wire logic [DATA_W-1:0]  file_rdata,
   output      logic               file_we,
   output      logic [FADDR_W-1:0] file_waddr,
   output      logic [DATA_W-1:0]  file_wdata,
   // page latch register contents
   input  wire logic [DATA_W-1:0]  page_latch_register,
   // return stack
   input  wire logic [PC_W-1:0]    stack_top,
   output      logic               stack_pop,
   // global_irq_enable set strobe, bit 7 of interrupt_control_register
   output      logic               global_irq_enable_set,
   // timer configuration register write strobe and data
   output      logic               timer_cfg_we,
   output      logic [DATA_W-1:0]  timer_cfg_wdata,
   // architectural state
   output      logic [DATA_W-1:0]  accumulator,
   output      logic               flag_zero,
   output      logic               flag_carry,
   output      logic               exec_busy
);

   //==========================================================
   // state
   mcis_state_t        state_r;
   mcis_state_t        state_nxt;
   logic [PC_W-1:0]    pc_r;
   logic [PC_W-1:0]    pc_nxt;
   logic [INSTR_W-1:0] ir_r;
   logic [FADDR_W-1:0] raddr_r;
   logic [DATA_W-1:0]  acc_r;
   logic               zero_r;
   logic               carry_r;
   logic               file_we_r;
   logic [FADDR_W-1:0] file_waddr_r;
   logic [DATA_W-1:0]  file_wdata_r;
   logic               stack_pop_r;
   logic               irq_set_r;
   logic               cfg_we_r;
   logic [DATA_W-1:0]  cfg_wdata_r;
   logic               busy_r;

   //==========================================================
   // decoded controls
   logic               executing;
   logic               dest_file;
   logic               byte_op;
   logic               skip_met;
   logic               redirect;
   logic               pops;
   logic [DATA_W-1:0]  operand;
   logic [FADDR_W-1:0] faddr;

   mcis_exec_if ex ();

   mcis_decode u_decode (
      .ex (ex.dec)
   );

   mcis_alu u_alu (
      .ex (ex.alu)
   );

   //==========================================================
   // operand path
   // a register write lands one cycle late, so forward it to a reader
   // of the same address to avoid reading the stale value
   assign faddr   = ir_r[FADDR_LSB +: FADDR_W]; // RULE1
   assign operand = (file_we_r && (file_waddr_r == raddr_r)) ? file_wdata_r : file_rdata;

   // in a flush cycle the discarded word is replaced by an empty instruction
   assign ex.instr    = executing ? ir_r : IR_RST; // RULE4
   assign ex.operand  = operand;
   assign ex.acc      = acc_r;
   assign ex.carry_in = carry_r;

   assign executing = (state_r == st_exec);
   assign dest_file = ir_r[DEST_BIT]; // RULE1

   always_comb begin
      case (ex.op)
         op_complement_reg,
         op_decrement_skip_zero,
         op_increment_skip_zero,
         op_move_reg,
         op_rotate_right_carry: byte_op = 1'b1;
         default:               byte_op = 1'b0;
      endcase
   end

   // skip only on a zero result of the counting instructions
   always_comb begin
      case (ex.op)
         op_decrement_skip_zero: skip_met = ex.zero; // RULE2
         op_increment_skip_zero: skip_met = ex.zero; // RULE3
         default:                skip_met = 1'b0;
      endcase
   end

   // every return form leaves through the stack; nothing is pushed here
   always_comb begin
      case (ex.op)
         op_return_from_irq,
         op_return_with_literal,
         op_return_sub: pops = 1'b1;
         default:       pops = 1'b0;
      endcase
   end

   assign redirect = pops || (ex.op == op_jump_absolute);

   //==========================================================
   // sequencing
   // every taken change of flow costs one extra cycle for the prefetch
   always_comb begin
      state_nxt = st_exec;
      case (state_r)
         st_exec: begin
            if (redirect || skip_met) begin
               state_nxt = st_flush; // RULE4 RULE7 RULE12 RULE15 RULE16
            end
         end
         st_flush: state_nxt = st_exec;
         default:  state_nxt = st_exec;
      endcase
   end

   always_comb begin
      pc_nxt = pc_r + PC_STEP; // RULE19
      case (ex.op)
         op_jump_absolute: begin
            pc_nxt = {page_latch_register[PAGE_HI:PAGE_LO], // RULE6
                      ir_r[JUMP_LSB +: JUMP_W]}; // RULE5
         end
         op_return_from_irq:     pc_nxt = stack_top; // RULE12
         op_return_with_literal: pc_nxt = stack_top; // RULE15
         op_return_sub:          pc_nxt = stack_top; // RULE16
         default:                pc_nxt = pc_r + PC_STEP;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= st_exec;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= PC_RST;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   // the fetch is latched every cycle; a flush only gates what executes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ir_r <= IR_RST;
      end else begin
         ir_r <= prog_data;
      end
   end

   // the read address leaves one cycle early so the operand is ready in time
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         raddr_r <= '0;
      end else begin
         raddr_r <= prog_data[FADDR_LSB +: FADDR_W]; // RULE1
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
      end else begin
         busy_r <= (state_nxt == st_flush);
      end
   end

   //==========================================================
   // accumulator and flags
   // flags are touched only by the instructions that name them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_r <= ACC_RST;
      end else begin
         case (ex.op)
            op_or_literal:          acc_r <= ex.result; // RULE8
            op_load_literal:        acc_r <= ex.result; // RULE9
            op_return_with_literal: acc_r <= ex.result; // RULE14
            default: begin
               if (byte_op && !dest_file) begin
                  acc_r <= ex.result; // RULE1
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         zero_r <= 1'b0;
      end else begin
         case (ex.op)
            op_complement_reg: zero_r <= ex.zero; // RULE18
            op_move_reg:       zero_r <= ex.zero; // RULE20
            op_or_literal:     zero_r <= ex.zero; // RULE8
            default:           zero_r <= zero_r;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         carry_r <= 1'b0;
      end else if (ex.op == op_rotate_right_carry) begin
         carry_r <= ex.carry_out; // RULE17
      end
   end

   //==========================================================
   // register file write-back
   // a move written back to itself is still issued, so the write strobe
   // shows even when the stored value does not change
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         file_we_r <= 1'b0;
      end else begin
         file_we_r <= (byte_op && dest_file) || (ex.op == op_store_accumulator); // RULE1 RULE11
      end
   end

   // address and data move every cycle; only the strobe qualifies them
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         file_waddr_r <= '0;
      end else begin
         file_waddr_r <= faddr;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         file_wdata_r <= '0;
      end else begin
         file_wdata_r <= ex.result;
      end
   end

   //==========================================================
   // side effects outside the core
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stack_pop_r <= 1'b0;
      end else begin
         stack_pop_r <= pops; // RULE12 RULE15 RULE16
      end
   end

   // a pulse, not a level: the enable bit itself lives outside the core
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_set_r <= 1'b0;
      end else begin
         irq_set_r <= (ex.op == op_return_from_irq); // RULE12
      end
   end

   // the timer configuration stays reachable as an ordinary register; this
   // strobe is only the legacy path and owns no copy of its own
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_we_r <= 1'b0;
      end else begin
         cfg_we_r <= (ex.op == op_load_timer_cfg); // RULE13
      end
   end

   // data follows the accumulator every cycle; only the strobe qualifies it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_wdata_r <= '0;
      end else begin
         cfg_wdata_r <= acc_r;
      end
   end

   //==========================================================
   // outputs
   assign prog_addr             = pc_r;
   assign file_raddr            = raddr_r;
   assign file_we               = file_we_r;
   assign file_waddr            = file_waddr_r;
   assign file_wdata            = file_wdata_r;
   assign stack_pop             = stack_pop_r;
   assign global_irq_enable_set = irq_set_r;
   assign timer_cfg_we          = cfg_we_r;
   assign timer_cfg_wdata       = cfg_wdata_r;
   assign accumulator           = acc_r;
   assign flag_zero             = zero_r;
   assign flag_carry            = carry_r;
   assign exec_busy             = busy_r;

endmodule // mcis_core

// file: verif/mcis_core_assertions.sv
// checker: port-level timing and results of the execution core
`timescale 1ns/100ps
module mcis_core_chk
   import mcis_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst_b,
   input wire logic [PC_W-1:0]    prog_addr,
   input wire logic [INSTR_W-1:0] prog_data,
   input wire logic [DATA_W-1:0]  file_rdata,
   input wire logic               file_we,
   input wire logic [FADDR_W-1:0] file_waddr,
   input wire logic [DATA_W-1:0]  file_wdata,
   input wire logic [DATA_W-1:0]  page_latch_register,
   input wire logic [PC_W-1:0]    stack_top,
   input wire logic               stack_pop,
   input wire logic               global_irq_enable_set,
   input wire logic               timer_cfg_we,
   input wire logic [DATA_W-1:0]  timer_cfg_wdata,
   input wire logic [DATA_W-1:0]  accumulator,
   input wire logic               flag_zero,
   input wire logic               flag_carry,
   input wire logic               exec_busy
);
   //==========================================================
   // word in execution; a flush cycle runs nothing
   logic [INSTR_W-1:0] ir_r;
   logic               live;
   logic               zres;
   logic               rc;
   logic [DATA_W-1:0]  lit;
   logic [DATA_W-1:0]  rot;
   logic [FADDR_W-1:0] fa;
   logic [PC_W-1:0]    tgt;
   logic [PC_W-1:0]    pc1;
   logic [DATA_W-1:0]  opd;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) ir_r <= IR_RST;
      else ir_r <= prog_data;
   end
   assign live = !exec_busy;
   assign lit  = ir_r[7:0];
   assign fa   = ir_r[6:0];
   // the core forwards last cycle's write, so the operand model must too
   assign opd  = (file_we && (file_waddr == fa)) ? file_wdata : file_rdata;
   assign rc   = opd[0];
   assign rot  = {flag_carry, opd[7:1]};
   assign tgt  = {page_latch_register[4:3], ir_r[10:0]};
   assign pc1  = prog_addr + PC_STEP;
   // skip result depends on which of the two counting forms runs
   assign zres = (ir_r[13:8] == 6'h0B) ? (opd == 8'h01) : (opd == 8'hFF);

   //==========================================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_flush;
      exec_busy ##1 !exec_busy;
   endsequence
   a_jump_target: assert property (
      live && ir_r[13:11] == 3'b101 |=> (prog_addr == $past(tgt)) ##0 s_flush)
      else $error("jump target or flush wrong");
   a_skip_flush: assert property (
      live && (ir_r[13:8] == 6'h0B || ir_r[13:8] == 6'h0F)
      |=> exec_busy == $past(zres) && $stable(flag_zero) && $stable(flag_carry))
      else $error("skip decision or flags wrong");
   a_return_pop: assert property (
      live && (ir_r == 14'h0008 || ir_r == 14'h0009 || ir_r[13:10] == 4'hD)
      |=> (prog_addr == $past(stack_top) && stack_pop) ##0 s_flush)
      else $error("return did not pop stack");
   a_irq_enable: assert property (
      live && ir_r == 14'h0009 |=> global_irq_enable_set)
      else $error("irq return left enable unset");
   a_ret_literal: assert property (
      live && ir_r[13:10] == 4'hD |=> accumulator == $past(lit) && $stable(flag_zero))
      else $error("return literal value wrong");
   a_timer_load: assert property (
      live && ir_r == 14'h0062
      |=> timer_cfg_we && timer_cfg_wdata == $past(accumulator) && $stable(flag_zero))
      else $error("timer config load wrong");
   a_store_write: assert property (
      live && ir_r[13:7] == 7'h01 |=> file_we && file_waddr == $past(fa)
      && file_wdata == $past(accumulator) && $stable(flag_zero))
      else $error("store write wrong");
   a_or_literal: assert property (
      live && ir_r[13:8] == 6'h38 |=> accumulator == ($past(accumulator) | $past(lit))
      && flag_zero == (accumulator == 8'h00) && $stable(flag_carry))
      else $error("or literal wrong");
   a_load_literal: assert property (
      live && ir_r[13:10] == 4'hC
      |=> accumulator == $past(lit) && $stable(flag_zero) && $stable(flag_carry))
      else $error("load literal wrong");
   a_rotate_acc: assert property (
      live && ir_r[13:7] == 7'h18 |=> accumulator == $past(rot)
      && flag_carry == $past(rc) && $stable(flag_zero))
      else $error("rotate right wrong");
   a_nop_advance: assert property (
      live && ir_r == 14'h0000
      |=> prog_addr == $past(pc1) && !file_we && $stable(accumulator))
      else $error("no-operation changed state");
endmodule // mcis_core_chk

bind mcis_core mcis_core_chk chk (.clk, .rst_b, .prog_addr, .prog_data, .file_rdata,
   .file_we, .file_waddr, .file_wdata, .page_latch_register, .stack_top, .stack_pop,
   .global_irq_enable_set, .timer_cfg_we, .timer_cfg_wdata, .accumulator, .flag_zero,
   .flag_carry, .exec_busy);

// file: verif/mcis_core_tb_top.sv
// testbench: directed programs run through the execution core
`timescale 1ns/100ps
module mcis_core_tb_top import mcis_pkg::*;;
   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic [PC_W-1:0]    prog_addr;
   logic [INSTR_W-1:0] prog_data;
   logic [FADDR_W-1:0] file_raddr;
   logic [DATA_W-1:0]  file_rdata;
   logic               file_we;
   logic [FADDR_W-1:0] file_waddr;
   logic [DATA_W-1:0]  file_wdata;
   logic [DATA_W-1:0]  page_latch_register = 8'h18;
   logic [PC_W-1:0]    stack_top = 13'h0ABC;
   logic               stack_pop;
   logic               global_irq_enable_set;
   logic               timer_cfg_we;
   logic [DATA_W-1:0]  timer_cfg_wdata;
   logic [DATA_W-1:0]  accumulator;
   logic               flag_zero;
   logic               flag_carry;
   logic               exec_busy;
   logic [INSTR_W-1:0] mem [0:8191];
   logic [DATA_W-1:0]  rf [0:127];
   logic [DATA_W-1:0]  tcfg_val;
   logic [15:0]        st_view;
   logic [15:0]        wr_view;
   int                 errors = 0;
   int                 check_count = 0;
   int                 pops;
   int                 irqs;

   //==========================================================
   // memories and views; a write lands in the file one edge late, the core forwards
   always #5 clk = ~clk;
   assign prog_data  = mem[prog_addr];
   assign file_rdata = rf[file_raddr];
   assign st_view    = {flag_zero, flag_carry, 4'h0, exec_busy, 1'b0, accumulator};
   assign wr_view    = {file_we, file_waddr, file_wdata};
   always @(posedge clk) begin
      if (file_we) rf[file_waddr] <= file_wdata;
      if (!rst_b) begin
         pops     <= 0;
         irqs     <= 0;
         tcfg_val <= 8'h00;
      end else begin
         if (stack_pop) pops <= pops + 1;
         if (global_irq_enable_set) irqs <= irqs + 1;
         if (timer_cfg_we) tcfg_val <= timer_cfg_wdata;
      end
   end
   mcis_core dut (.clk, .rst_b, .prog_addr, .prog_data, .file_raddr, .file_rdata, .file_we,
      .file_waddr, .file_wdata, .page_latch_register, .stack_top, .stack_pop,
      .global_irq_enable_set, .timer_cfg_we, .timer_cfg_wdata, .accumulator, .flag_zero,
      .flag_carry, .exec_busy);

   //==========================================================
   // shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic see(input logic [15:0] pa, input logic [15:0] st);
      @(posedge clk);
      #1;
      chk(16'(prog_addr), pa);
      chk(st_view, st);
   endtask
   task automatic load(input logic [12:0] base, input logic [13:0] p[$]);
      foreach (p[i]) mem[base + 13'(i)] = p[i];
   endtask
   task automatic clear();
      for (int i = 0; i < 8192; i++) mem[i] = 14'h0000;
      for (int i = 0; i < 128; i++) rf[i] = 8'h00;
   endtask
   task automatic boot();
      rst_b = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      @(posedge clk);
      #1;
   endtask

   //==========================================================
   // scenarios
   task automatic t_file_ops();
      clear();
      load(13'h0000, '{14'h305A, 14'h0090, 14'h0910, 14'h0990, 14'h3300, 14'h3800,
                       14'h0810, 14'h0060, 14'h0891});
      boot();
      see(16'h0002, 16'h005A);
      see(16'h0003, 16'h005A);
      chk(wr_view, 16'h905A);
      chk(16'(file_raddr), 16'h0010);
      see(16'h0004, 16'h00A5);
      see(16'h0005, 16'h00A5);
      chk(wr_view, 16'h90A5);
      see(16'h0006, 16'h0000);
      see(16'h0007, 16'h8000);
      see(16'h0008, 16'h00A5);
      see(16'h0009, 16'h00A5);
      chk(16'(file_we), 16'h0000);
      see(16'h000A, 16'h80A5);
      chk(wr_view, 16'h9100);
   endtask
   task automatic t_rotate_cfg();
      clear();
      rf[7'h20] = 8'h81;
      load(13'h0000, '{14'h0C20, 14'h0CA0, 14'h0C21, 14'h0C21, 14'h303C, 14'h0062, 14'h00A2});
      boot();
      see(16'h0002, 16'h4040);
      see(16'h0003, 16'h4040);
      chk(wr_view, 16'hA0C0);
      see(16'h0004, 16'h0080);
      see(16'h0005, 16'h0000);
      see(16'h0006, 16'h003C);
      see(16'h0007, 16'h003C);
      see(16'h0008, 16'h003C);
      chk(wr_view, 16'hA23C);
      chk(16'(tcfg_val), 16'h003C);
   endtask
   task automatic t_skips();
      clear();
      rf[7'h30] = 8'h01;
      rf[7'h31] = 8'hFF;
      rf[7'h32] = 8'h05;
      load(13'h0000, '{14'h3800, 14'h0BB0, 14'h3011, 14'h0F31, 14'h3022, 14'h0B32, 14'h3033});
      boot();
      see(16'h0002, 16'h8000);
      see(16'h0003, 16'h8200);
      chk(wr_view, 16'hB000);
      see(16'h0004, 16'h8000);
      see(16'h0005, 16'h8200);
      see(16'h0006, 16'h8000);
      see(16'h0007, 16'h8004);
      see(16'h0008, 16'h8033);
   endtask
   task automatic t_flow();
      clear();
      stack_top = 13'h0ABC;
      load(13'h0000, '{14'h2923, 14'h3099});
      load(13'h1923, '{14'h345C, 14'h30EE});
      load(13'h0ABC, '{14'h0008, 14'h30EE});
      load(13'h0100, '{14'h0009, 14'h30EE});
      boot();
      see(16'h1923, 16'h0200);
      see(16'h1924, 16'h0000);
      see(16'h0ABC, 16'h025C);
      stack_top = 13'h0100;
      see(16'h0ABD, 16'h005C);
      see(16'h0100, 16'h025C);
      stack_top = 13'h0040;
      see(16'h0101, 16'h005C);
      see(16'h0040, 16'h025C);
      see(16'h0041, 16'h005C);
      chk(16'(pops), 16'h0003);
      chk(16'(irqs), 16'h0001);
   endtask

   //==========================================================
   // verdict
   task automatic results();
      $display("errors=%0d checks=%0d", errors, check_count);
      if (errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // about 60 cycles of work; the limit leaves ample margin
   initial begin
      #5000;
      errors++;
      results();
   end
   initial begin
      t_file_ops();
      t_rotate_cfg();
      t_skips();
      t_flow();
      results();
   end
endmodule // mcis_core_tb_top
